// ===== verif/hio_chk.sv
// Port-level assertions for the high-speed I/O command block
`timescale 1ns/1ps
module hio_chk (
   input wire        clk,               // Clock
   input wire        rst,               // Sync reset
   input wire        ce,                // Clock enable
   input wire [7:0]  avs_address,       // Byte address
   input wire        avs_read,          // Read request
   input wire        avs_write,         // Write request
   input wire        avs_waitrequest,   // Stall
   input wire [31:0] avs_readdata,      // Read data
   input wire [15:0] input_edge_select, // Input edges
   input wire [3:0]  probe_capture_edge,// Probe edges
   input wire [7:0]  cnt_error_flag     // Held errors
);
   wire acc_ctl = avs_write && !avs_waitrequest && (avs_address == 8'h00);
   wire [15:0] both_bits = input_edge_select & (input_edge_select >> 1) & 16'h5555;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req; ce && (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
   chk_bus_answer: assert property (s_req |=> s_ack)
      else $error("Access not answered after one wait");
   chk_bus_quiet: assert property (ce && !avs_read && !avs_write && avs_waitrequest
      |=> avs_waitrequest)
      else $error("Answer without request");
   chk_reset_idle: assert property ($fell(rst) |-> avs_waitrequest && avs_readdata == 32'h0
      && input_edge_select == 16'h0 && cnt_error_flag == 8'h0)
      else $error("Outputs not cleared by reset");
   chk_read_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
      else $error("Read data moved outside a read");
   chk_edge_cause: assert property ($changed(input_edge_select) |-> $past(acc_ctl, 2))
      else $error("Input edge moved without execute");
   chk_probe_cause: assert property ($changed(probe_capture_edge) |-> $past(acc_ctl, 2))
      else $error("Probe edge moved without execute");
   chk_flag_hold: assert property ($changed(cnt_error_flag) |-> $past(acc_ctl, 2))
      else $error("Error flag moved without command");
   chk_edge_code: assert property (both_bits == 16'h0000)
      else $error("Input edge holds code 3");
endmodule
bind hio_irq_param hio_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .avs_readdata(avs_readdata), .input_edge_select(input_edge_select),
   .probe_capture_edge(probe_capture_edge), .cnt_error_flag(cnt_error_flag));

// ===== verif/hio_far.sv
// Counter-side status levels seen by the command block
`timescale 1ns/1ps
module hio_far (
   input  wire        fault_on,         // Select faulty configuration
   output wire [7:0]  func_chosen,      // Function per counter
   output wire [7:0]  cnt_enabled,      // Counter enabled
   output wire [7:0]  cnt_ovf_fault,    // Overflow state wrong
   output wire [3:0]  ring_format,      // Ring mode per special counter
   output wire [11:0] irq_input_chosen  // Interrupt inputs
);
   // Faulty: counter 2 bare, 3 overflow, 4 off, 0 not ring, input 7 not chosen
   assign func_chosen      = fault_on ? 8'hFB : 8'hFF;
   assign cnt_enabled      = fault_on ? 8'hEF : 8'hFF;
   assign cnt_ovf_fault    = fault_on ? 8'h08 : 8'h00;
   assign ring_format      = fault_on ? 4'hE : 4'hF;
   assign irq_input_chosen = fault_on ? 12'hF7F : 12'hFFF;
endmodule

// ===== verif/tb.sv
// Self-checking bench for the high-speed I/O command block
`timescale 1ns/1ps
module tb;
   reg         clk = 0, rst = 1, avs_read = 0, avs_write = 0, fault_on = 0;
   reg  [7:0]  avs_address = 8'h00;
   reg  [31:0] avs_writedata = 32'h0, q;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire [7:0]  fc, en, ovf, flg;
   wire [3:0]  rf, pce;
   wire [11:0] ic;
   wire [15:0] ies;
   integer     seed = 26, bad_count = 0, num_checks = 0, i, n, v, k, e;
   integer     e_in [0:7], e_pr [0:3], flag [0:7], eid [0:7];
   reg  [15:0] x_in;
   reg  [3:0]  x_pr;
   reg  [7:0]  x_fl;
   // Check rows: kind, channel, operand a, operand b, code
   integer tk [0:21] = '{1,4,1,1,1,4,1,1,2,2,2,3,3,4,4,5,5,5,6,7,8,9};
   integer tc [0:21] = '{9,5,2,3,4,0,1,1,1,1,5,5,6,1,1,6,6,7,7,7,6,6};
   integer ta [0:21] = '{0,1,0,0,0,1,30001,30000,0,101,100,'h80000000,5,5,'h7FFFFFFF,9,
                         65536,10,0,0,0,1};
   integer tb_ [0:21] = '{0,9,0,0,0,9,0,0,0,0,30001,0,4,5,9,0,0,0,0,0,0,0};
   integer tx [0:21] = '{1,513,4,3,7,515,501,0,502,502,509,503,510,516,518,517,517,0,
                         504,505,508,511};
   always #4 clk = ~clk;
   hio_far u_far (.fault_on(fault_on), .func_chosen(fc), .cnt_enabled(en),
      .cnt_ovf_fault(ovf), .ring_format(rf), .irq_input_chosen(ic));
   hio_irq_param u_dut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .func_chosen(fc), .cnt_enabled(en), .cnt_ovf_fault(ovf), .ring_format(rf),
      .irq_input_chosen(ic), .input_edge_select(ies), .probe_capture_edge(pce),
      .cnt_error_flag(flg));
   task finish_test;
      begin
         $display("checks %0d errors %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task check(input [31:0] s, input [31:0] x);
      begin
         num_checks = num_checks + 1;
         if (s !== x) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      integer t;
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_write <= w;
         avs_read <= !w;
         t = 0;
         do begin @(posedge clk); t = t + 1; end while (avs_waitrequest !== 1'b0 && t < 50);
         if (t >= 50) begin bad_count = bad_count + 1; finish_test; end
         q = avs_readdata;
         avs_write <= 0;
         avs_read <= 0;
         @(posedge clk);
      end
   endtask
   task exec(input integer b);
      begin bus(1, 8'h00, 32'h1 << b); bus(1, 8'h00, 32'h0); end
   endtask
   task outs;
      begin
         for (n = 0; n < 8; n = n + 1) x_in[2*n +: 2] = e_in[n];
         for (n = 0; n < 4; n = n + 1) x_pr[n] = e_pr[n];
         for (n = 0; n < 8; n = n + 1) x_fl[n] = flag[n];
         check(ies, x_in);
         check(pce, x_pr);
         check(flg, x_fl);
         bus(0, 8'h2C, 0);
         check(q, {x_pr, x_in});
         for (n = 0; n < 8; n = n + 1) begin
            bus(1, 8'h30, n);
            bus(0, 8'h34, 0);
            check(q, eid[n]);
         end
      end
   endtask
   task irq(input integer pn, input integer val);
      begin
         k = pn - 10080;
         if (k < 0 || k > 11 || val > ((k < 8) ? 2 : 1)) e = 1101;
         else e = ((fault_on ? 12'hF7F : 12'hFFF) >> k) & 1 ? 0 : 1102;
         if (e == 0 && k < 8) e_in[k] = val;
         if (e == 0 && k >= 8) e_pr[k-8] = val;
         bus(1, 8'h04, pn);
         bus(1, 8'h08, val);
         exec(0);
         bus(0, 8'h20, 0);
         check(q, e);
         bus(0, 8'h1C, 0);
         check(q[1:0], {e != 0, 1'b1});
         outs;
      end
   endtask
   initial begin
      for (n = 0; n < 8; n = n + 1) begin
         e_in[n] = 0;
         e_pr[n%4] = 0;
         flag[n] = 0;
         eid[n] = 0;
      end
      repeat (10) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      bus(0, 8'h1C, 0);
      check(q, 32'h0);
      bus(1, 8'h40, 32'hFFFFFFFF);
      bus(0, 8'h40, 0);
      check(q, 32'h0);
      outs;
      for (i = 0; i < 24; i = i + 1) begin
         n = {$random(seed)} % 12;
         v = {$random(seed)} % ((n < 8) ? 3 : 2);
         irq(10080 + n, v);
      end
      irq(10079, 0);
      irq(10092, 0);
      irq(10080, 3);
      irq(10088, 2);
      // Second execute without a low phase must not act
      bus(1, 8'h04, 10081);
      bus(1, 8'h08, 1);
      bus(1, 8'h00, 1);
      e_in[1] = 1;
      bus(1, 8'h08, 2);
      bus(1, 8'h00, 1);
      bus(1, 8'h00, 0);
      outs;
      fault_on <= 1;
      @(posedge clk);
      irq(10087, 1);
      for (i = 0; i < 22; i = i + 1) begin
         bus(1, 8'h10, (tc[i] << 8) | tk[i]);
         bus(1, 8'h14, ta[i]);
         bus(1, 8'h18, tb_[i]);
         exec(2);
         e = tx[i] ? (2 + tk[i]) * 1000 + tx[i] : 0;
         if (tc[i] < 8) flag[tc[i]] = tx[i] != 0;
         if (tc[i] < 8) eid[tc[i]] = e;
         bus(0, 8'h28, 0);
         check(q, e);
         bus(0, 8'h1C, 0);
         check(q[5:4], {tx[i] != 0, 1'b1});
         if (tx[i]) check(q[6], tx[i] < 500);
         outs;
      end
      for (i = 0; i < 3; i = i + 1) begin
         v = (i == 0) ? 6 : (i == 1) ? 8 : 1;
         bus(1, 8'h0C, v);
         exec(1);
         if (v < 8) flag[v] = 0;
         if (v < 8) eid[v] = 0;
         bus(0, 8'h24, 0);
         check(q, (v > 7) ? 2001 : 0);
         bus(0, 8'h1C, 0);
         check(q[3:2], {v > 7, 1'b1});
         outs;
      end
      finish_test;
   end
endmodule

// ===== verilog/hio_defs.vh
// Offsets, field positions, limits and code constants of the high-speed I/O command block
`ifndef HIO_DEFS_VH
`define HIO_DEFS_VH

// Register byte offsets
`define HIO_ADDR_CTRL        8'h00
`define HIO_ADDR_PARAM_INDEX 8'h04
`define HIO_ADDR_PARAM_VALUE 8'h08
`define HIO_ADDR_CLR_CHAN    8'h0C
`define HIO_ADDR_CHK_CMD     8'h10
`define HIO_ADDR_CHK_OPA     8'h14
`define HIO_ADDR_CHK_OPB     8'h18
`define HIO_ADDR_STATUS      8'h1C
`define HIO_ADDR_IRQ_ERRID   8'h20
`define HIO_ADDR_CLR_ERRID   8'h24
`define HIO_ADDR_CHK_ERRID   8'h28
`define HIO_ADDR_EDGE_SEL    8'h2C
`define HIO_ADDR_CNT_SEL     8'h30
`define HIO_ADDR_CNT_ERRID   8'h34

// Control bits
`define HIO_CTRL_IRQ_EXEC    0
`define HIO_CTRL_CLR_EXEC    1
`define HIO_CTRL_CHK_EXEC    2

// Status bits
`define HIO_ST_IRQ_DONE      0
`define HIO_ST_IRQ_ERR       1
`define HIO_ST_CLR_DONE      2
`define HIO_ST_CLR_ERR       3
`define HIO_ST_CHK_DONE      4
`define HIO_ST_CHK_ERR       5
`define HIO_ST_CHK_SERIOUS   6

// Parameter numbers of the interrupt-parameter write
`define HIO_PN_IN_FIRST      32'h00002760
`define HIO_PN_IN_LAST       32'h00002767
`define HIO_PN_PRB_FIRST     32'h00002768
`define HIO_PN_PRB_LAST      32'h0000276B
`define HIO_EDGE_BOTH        8'h02
`define HIO_EDGE_FALL        8'h01

// Identifier layout: library*100000 + command*1000 + code
`define HIO_LIBRARY          7'h00
`define HIO_ID_SCALE         17'h003E8
`define HIO_CMD_IRQ_WRITE    7'h01
`define HIO_CMD_ERR_CLEAR    7'h02
`define HIO_CMD_CHK_BASE     7'h02
`define HIO_SERIOUS_LIMIT    10'h1F4

// Error codes
`define HIO_E_NONE           10'h000
`define HIO_E_CHAN           10'h001
`define HIO_E_OVF            10'h003
`define HIO_E_NOT_CHOSEN     10'h004
`define HIO_E_NOT_ENABLED    10'h007
`define HIO_E_IRQ_PARAM      10'h065
`define HIO_E_IRQ_NOT_CHOSEN 10'h066
`define HIO_E_CMP_TIME       10'h1F5
`define HIO_E_CMPM_NUM       10'h1F6
`define HIO_E_PRESET_VAL     10'h1F7
`define HIO_E_AVERAGE        10'h1F8
`define HIO_E_ROTATION       10'h1F9
`define HIO_E_WIDTH          10'h1FC
`define HIO_E_CMPM_TIME      10'h1FD
`define HIO_E_PRESET_TRIG    10'h1FE
`define HIO_E_PARAM          10'h1FF
`define HIO_E_SPECIAL_CHAN   10'h201
`define HIO_E_NOT_RING       10'h203
`define HIO_E_RING_ORDER     10'h204
`define HIO_E_SAMPLE         10'h205
`define HIO_E_RING_VAL       10'h206

// Check command kinds
`define HIO_K_COMPARE        4'h1
`define HIO_K_COMPARE_M      4'h2
`define HIO_K_PRESET         4'h3
`define HIO_K_RING           4'h4
`define HIO_K_SAMPLE         4'h5
`define HIO_K_AVERAGE        4'h6
`define HIO_K_ROTATION       4'h7
`define HIO_K_WIDTH          4'h8

// Limits
`define HIO_TIME_MAX         32'h00007530
`define HIO_CMPM_MIN         32'h00000001
`define HIO_CMPM_MAX         32'h00000064
`define HIO_SAMPLE_MIN       32'h0000000A
`define HIO_SAMPLE_MAX       32'h0000FFFF
`define HIO_DINT_MIN         32'h80000000
`define HIO_DINT_MAX         32'h7FFFFFFF
`define HIO_TRIG_MAX         32'h00000003

`endif

// ===== verilog/hio_irq_param.v
// Interrupt-parameter write, error clear and error-identifier reporting over Avalon-MM
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "hio_defs.vh"
// Overview of operation
// - Parameter write starts on execute rising edge
// - Numbers 10080-10087 set input edge 0-2
// - Numbers 10088-10091 set probe edge 0-1
// - Done is one when finished, else zero
// - Clear takes counter 0-7, on rising edge
// - Identifier is library, command, three-digit code
// - Command numbers and codes start at 01
// - Codes under 500 serious, above command-level
// - Channel outside 0-7 gives code 001
// - Bad overflow or underflow gives code 003
// - Unconfigured gives 004, counter disabled gives 007
// - Bad write 101, not interrupt input 102
// - Output time over 30000 gives 501/509
// - Compare count outside 1-100 gives 502
// - Special channel outside 0-3 gives 513
// - Ring lower not below upper gives 516
// - Not ring mode 515, ring value 518
// - Sampling outside 10-65535 ms gives 517
// - Preset value 503, preset trigger 510
// - Averaging 504, pulses 505, width 508
module hio_irq_param #(
   parameter N_CNT = 8,
   parameter N_SPECIAL = 4,
   parameter N_IN = 8
) (
   input  wire        clk,                  // 125 MHz clock
   input  wire        rst,                  // Synchronous reset, active high
   input  wire        ce,                   // Clock enable, freezes all state when low
   input  wire [7:0]  avs_address,          // Byte address
   input  wire        avs_read,             // Read request
   input  wire        avs_write,            // Write request
   input  wire [31:0] avs_writedata,        // Write data
   input  wire [3:0]  avs_byteenable,       // Byte lanes
   output reg  [31:0] avs_readdata,         // Read data
   output reg         avs_waitrequest,      // Stall
   input  wire [7:0]  func_chosen,          // Counter has a high-speed function
   input  wire [7:0]  cnt_enabled,          // Counter enabled
   input  wire [7:0]  cnt_ovf_fault,        // Counter overflow state wrong
   input  wire [3:0]  ring_format,          // Special counter set for ring counting
   input  wire [11:0] irq_input_chosen,     // Input configured as interrupt input
   output reg  [15:0] input_edge_select,    // Two bits per interrupt input
   output reg  [3:0]  probe_capture_edge,   // One bit per probe counter, 1 falling
   output reg  [7:0]  cnt_error_flag        // Held error flag per counter
);

   // Bus and command registers
   reg  [2:0]  exec_r;
   reg  [2:0]  exec_d_r;
   reg  [31:0] param_index_r;
   reg  [7:0]  param_value_r;
   reg  [7:0]  clr_chan_r;
   reg  [3:0]  chk_kind_r;
   reg  [7:0]  chk_chan_r;
   reg  [31:0] chk_opa_r;
   reg  [31:0] chk_opb_r;
   reg  [2:0]  cnt_sel_r;
   reg         irq_done_r;
   reg         irq_err_r;
   reg  [15:0] irq_id_r;
   reg         clr_done_r;
   reg         clr_err_r;
   reg  [15:0] clr_id_r;
   reg         chk_done_r;
   reg         chk_err_r;
   reg         chk_serious_r;
   reg  [15:0] chk_id_r;
   reg  [15:0] cnt_id_r [0:N_CNT-1];

   wire [2:0]  exec_rise;
   wire        bus_req;
   wire        wr_acc;
   wire [31:0] be_mask;
   reg  [31:0] rd_mux;
   reg  [9:0]  irq_code;
   reg  [9:0]  clr_code;
   reg  [9:0]  chk_code;
   reg  [3:0]  irq_slot;
   wire [6:0]  chk_cmd;
   wire [2:0]  chk_ch3;
   wire [2:0]  clr_ch3;

   assign exec_rise = exec_r & ~exec_d_r;
   assign bus_req   = avs_read | avs_write;
   assign wr_acc    = avs_write & ~avs_waitrequest;
   assign be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign chk_cmd   = `HIO_CMD_CHK_BASE + {3'h0, chk_kind_r};
   assign chk_ch3   = chk_chan_r[2:0];
   assign clr_ch3   = clr_chan_r[2:0];

   // Byte-lane merge of a write into an old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] m;
      begin
         merge = (old & ~m) | (wd & m);
      end
   endfunction

   // Library, command number and code packed as one decimal identifier
   function [15:0] make_id;
      input [6:0] cmd;
      input [9:0] code;
      reg   [16:0] t;
      begin
         t = ({10'h000, `HIO_LIBRARY} * 17'h186A0) + ({10'h000, cmd} * `HIO_ID_SCALE)
             + {7'h00, code};
         make_id = t[15:0];
      end
   endfunction

   // Interrupt-parameter write check
   always @* begin
      irq_code = `HIO_E_NONE;
      irq_slot = 4'h0;
      if (param_index_r >= `HIO_PN_IN_FIRST && param_index_r <= `HIO_PN_IN_LAST) begin
         irq_slot = param_index_r[3:0] - 4'h0;
         if (param_value_r > `HIO_EDGE_BOTH)
            irq_code = `HIO_E_IRQ_PARAM;
         else if (!irq_input_chosen[irq_slot])
            irq_code = `HIO_E_IRQ_NOT_CHOSEN;
      end else if (param_index_r >= `HIO_PN_PRB_FIRST &&
                   param_index_r <= `HIO_PN_PRB_LAST) begin
         irq_slot = param_index_r[3:0];
         if (param_value_r > `HIO_EDGE_FALL)
            irq_code = `HIO_E_IRQ_PARAM;
         else if (!irq_input_chosen[irq_slot])
            irq_code = `HIO_E_IRQ_NOT_CHOSEN;
      end else begin
         irq_code = `HIO_E_IRQ_PARAM;
      end
   end

   // Error-clear check
   always @* begin
      clr_code = `HIO_E_NONE;
      if (clr_chan_r > (N_CNT - 1))
         clr_code = `HIO_E_CHAN;
   end

   // Counter command checks: channel 001, then special channel 513, then serious faults 004, 003, 007, then command-level ones
   always @* begin
      chk_code = `HIO_E_NONE;
      if (chk_chan_r > (N_CNT - 1))
         chk_code = `HIO_E_CHAN;
      else if (chk_kind_r == `HIO_K_RING && chk_chan_r > (N_SPECIAL - 1))
         chk_code = `HIO_E_SPECIAL_CHAN;
      else if (!func_chosen[chk_ch3])
         chk_code = `HIO_E_NOT_CHOSEN;
      else if (cnt_ovf_fault[chk_ch3])
         chk_code = `HIO_E_OVF;
      else if (!cnt_enabled[chk_ch3])
         chk_code = `HIO_E_NOT_ENABLED;
      else begin
         case (chk_kind_r)
            `HIO_K_COMPARE: begin
               if (chk_opa_r > `HIO_TIME_MAX)
                  chk_code = `HIO_E_CMP_TIME;
            end
            `HIO_K_COMPARE_M: begin
               if (chk_opa_r < `HIO_CMPM_MIN || chk_opa_r > `HIO_CMPM_MAX)
                  chk_code = `HIO_E_CMPM_NUM;
               else if (chk_opb_r > `HIO_TIME_MAX)
                  chk_code = `HIO_E_CMPM_TIME;
            end
            `HIO_K_PRESET: begin
               if (chk_opa_r == `HIO_DINT_MIN || chk_opa_r == `HIO_DINT_MAX)
                  chk_code = `HIO_E_PRESET_VAL;
               else if (chk_opb_r > `HIO_TRIG_MAX)
                  chk_code = `HIO_E_PRESET_TRIG;
            end
            `HIO_K_RING: begin
               if (!ring_format[chk_chan_r[1:0]])
                  chk_code = `HIO_E_NOT_RING;
               else if (chk_opa_r == `HIO_DINT_MIN || chk_opa_r == `HIO_DINT_MAX ||
                        chk_opb_r == `HIO_DINT_MIN || chk_opb_r == `HIO_DINT_MAX)
                  chk_code = `HIO_E_RING_VAL;
               else if ($signed(chk_opa_r) >= $signed(chk_opb_r))
                  chk_code = `HIO_E_RING_ORDER;
            end
            `HIO_K_SAMPLE: begin
               if (chk_opa_r < `HIO_SAMPLE_MIN || chk_opa_r > `HIO_SAMPLE_MAX)
                  chk_code = `HIO_E_SAMPLE;
            end
            `HIO_K_AVERAGE: begin
               if (chk_opa_r == 32'h00000000)
                  chk_code = `HIO_E_AVERAGE;
            end
            `HIO_K_ROTATION: begin
               if (chk_opa_r == 32'h00000000)
                  chk_code = `HIO_E_ROTATION;
            end
            `HIO_K_WIDTH: begin
               if (chk_opa_r == 32'h00000000)
                  chk_code = `HIO_E_WIDTH;
            end
            default: chk_code = `HIO_E_PARAM;
         endcase
      end
   end

   // Read mux
   always @* begin
      rd_mux = 32'h00000000;
      case (avs_address)
         `HIO_ADDR_CTRL:        rd_mux = {29'h00000000, exec_r};
         `HIO_ADDR_PARAM_INDEX: rd_mux = param_index_r;
         `HIO_ADDR_PARAM_VALUE: rd_mux = {24'h000000, param_value_r};
         `HIO_ADDR_CLR_CHAN:    rd_mux = {24'h000000, clr_chan_r};
         `HIO_ADDR_CHK_CMD:     rd_mux = {16'h0000, chk_chan_r, 4'h0, chk_kind_r};
         `HIO_ADDR_CHK_OPA:     rd_mux = chk_opa_r;
         `HIO_ADDR_CHK_OPB:     rd_mux = chk_opb_r;
         `HIO_ADDR_STATUS:      rd_mux = {16'h0000, cnt_error_flag, 1'b0, chk_serious_r,
                                          chk_err_r, chk_done_r, clr_err_r, clr_done_r,
                                          irq_err_r, irq_done_r};
         `HIO_ADDR_IRQ_ERRID:   rd_mux = {16'h0000, irq_id_r};
         `HIO_ADDR_CLR_ERRID:   rd_mux = {16'h0000, clr_id_r};
         `HIO_ADDR_CHK_ERRID:   rd_mux = {16'h0000, chk_id_r};
         `HIO_ADDR_EDGE_SEL:    rd_mux = {12'h000, probe_capture_edge, input_edge_select};
         `HIO_ADDR_CNT_SEL:     rd_mux = {29'h00000000, cnt_sel_r};
         `HIO_ADDR_CNT_ERRID:   rd_mux = {16'h0000, cnt_id_r[cnt_sel_r]};
         default:               rd_mux = 32'h00000000;
      endcase
   end

   // Avalon slave handshake: one wait state, then accept
   always @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if (ce) begin
         if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            if (avs_read)
               avs_readdata <= rd_mux;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // Software-written operand registers
   always @(posedge clk) begin
      if (rst) begin
         exec_r        <= 3'h0;
         exec_d_r      <= 3'h0;
         param_index_r <= 32'h00000000;
         param_value_r <= 8'h00;
         clr_chan_r    <= 8'h00;
         chk_kind_r    <= 4'h0;
         chk_chan_r    <= 8'h00;
         chk_opa_r     <= 32'h00000000;
         chk_opb_r     <= 32'h00000000;
         cnt_sel_r     <= 3'h0;
      end else if (ce) begin
         exec_d_r <= exec_r;
         if (wr_acc) begin
            case (avs_address)
               `HIO_ADDR_CTRL:
                  if (avs_byteenable[0])
                     exec_r <= avs_writedata[2:0];
               `HIO_ADDR_PARAM_INDEX:
                  param_index_r <= merge(param_index_r, avs_writedata, be_mask);
               `HIO_ADDR_PARAM_VALUE:
                  if (avs_byteenable[0])
                     param_value_r <= avs_writedata[7:0];
               `HIO_ADDR_CLR_CHAN:
                  if (avs_byteenable[0])
                     clr_chan_r <= avs_writedata[7:0];
               `HIO_ADDR_CHK_CMD: begin
                  if (avs_byteenable[0])
                     chk_kind_r <= avs_writedata[3:0];
                  if (avs_byteenable[1])
                     chk_chan_r <= avs_writedata[15:8];
               end
               `HIO_ADDR_CHK_OPA:
                  chk_opa_r <= merge(chk_opa_r, avs_writedata, be_mask);
               `HIO_ADDR_CHK_OPB:
                  chk_opb_r <= merge(chk_opb_r, avs_writedata, be_mask);
               `HIO_ADDR_CNT_SEL:
                  if (avs_byteenable[0])
                     cnt_sel_r <= avs_writedata[2:0];
               default: ;
            endcase
         end
      end
   end

   // Interrupt-parameter write execution
   always @(posedge clk) begin
      if (rst) begin
         irq_done_r         <= 1'b0;
         irq_err_r          <= 1'b0;
         irq_id_r           <= 16'h0000;
         input_edge_select  <= 16'h0000;
         probe_capture_edge <= 4'h0;
      end else if (ce) begin
         if (wr_acc && avs_address == `HIO_ADDR_CTRL && avs_byteenable[0] &&
             avs_writedata[`HIO_CTRL_IRQ_EXEC] && !exec_r[`HIO_CTRL_IRQ_EXEC])
            irq_done_r <= 1'b0;
         else if (exec_rise[`HIO_CTRL_IRQ_EXEC]) begin
            irq_done_r <= 1'b1;
            irq_err_r  <= (irq_code != `HIO_E_NONE);
            irq_id_r   <= (irq_code != `HIO_E_NONE) ?
                          make_id(`HIO_CMD_IRQ_WRITE, irq_code) : 16'h0000;
            if (irq_code == `HIO_E_NONE) begin
               if (irq_slot < N_IN)
                  input_edge_select[{irq_slot[2:0], 1'b0} +: 2] <= param_value_r[1:0];
               else
                  probe_capture_edge[irq_slot[1:0]] <= param_value_r[0];
            end
         end
      end
   end

   // Error-clear and counter-check execution with per-counter held errors
   always @(posedge clk) begin
      if (rst) begin
         clr_done_r     <= 1'b0;
         clr_err_r      <= 1'b0;
         clr_id_r       <= 16'h0000;
         chk_done_r     <= 1'b0;
         chk_err_r      <= 1'b0;
         chk_serious_r  <= 1'b0;
         chk_id_r       <= 16'h0000;
         cnt_error_flag <= 8'h00;
      end else if (ce) begin
         if (wr_acc && avs_address == `HIO_ADDR_CTRL && avs_byteenable[0] &&
             avs_writedata[`HIO_CTRL_CLR_EXEC] && !exec_r[`HIO_CTRL_CLR_EXEC])
            clr_done_r <= 1'b0;
         else if (exec_rise[`HIO_CTRL_CLR_EXEC]) begin
            clr_done_r <= 1'b1;
            clr_err_r  <= (clr_code != `HIO_E_NONE);
            clr_id_r   <= (clr_code != `HIO_E_NONE) ?
                          make_id(`HIO_CMD_ERR_CLEAR, clr_code) : 16'h0000;
            if (clr_code == `HIO_E_NONE)
               cnt_error_flag[clr_ch3] <= 1'b0;
         end
         if (wr_acc && avs_address == `HIO_ADDR_CTRL && avs_byteenable[0] &&
             avs_writedata[`HIO_CTRL_CHK_EXEC] && !exec_r[`HIO_CTRL_CHK_EXEC])
            chk_done_r <= 1'b0;
         else if (exec_rise[`HIO_CTRL_CHK_EXEC]) begin
            chk_done_r    <= 1'b1;
            chk_err_r     <= (chk_code != `HIO_E_NONE);
            chk_serious_r <= (chk_code != `HIO_E_NONE) &&
                             (chk_code < `HIO_SERIOUS_LIMIT);
            chk_id_r      <= (chk_code != `HIO_E_NONE) ? make_id(chk_cmd, chk_code) : 16'h0000;
            if (chk_chan_r < N_CNT)
               cnt_error_flag[chk_ch3] <= (chk_code != `HIO_E_NONE);
         end
      end
   end

   // Held identifier per counter, one entry per channel
   genvar gi;
   generate
      for (gi = 0; gi < N_CNT; gi = gi + 1) begin : g_cnt_id
         always @(posedge clk) begin
            if (rst)
               cnt_id_r[gi] <= 16'h0000;
            else if (ce) begin
               if (exec_rise[`HIO_CTRL_CHK_EXEC] && chk_chan_r == gi)
                  cnt_id_r[gi] <= (chk_code != `HIO_E_NONE) ?
                                  make_id(chk_cmd, chk_code) : 16'h0000;
               else if (exec_rise[`HIO_CTRL_CLR_EXEC] && clr_chan_r == gi)
                  cnt_id_r[gi] <= 16'h0000;
            end
         end
      end
   endgenerate

endmodule
